// ==== verilog/umsf_pkg.sv ====
// Package with register map, field positions, reset values and types for the modem status block.
package umsf_pkg;

  localparam logic [5:0] OFF_STATUS  = 6'h00;
  localparam logic [5:0] OFF_SCRATCH = 6'h04;
  localparam logic [5:0] OFF_FEATURE = 6'h08;
  localparam logic [5:0] OFF_IEN     = 6'h0C;
  localparam logic [5:0] OFF_ISTAT   = 6'h10;
  localparam logic [5:0] OFF_MCTRL   = 6'h14;
  localparam logic [5:0] OFF_FLOW    = 6'h18;
  localparam logic [5:0] OFF_CHAR0   = 6'h20;
  localparam logic [5:0] OFF_CHAR3   = 6'h2C;

  localparam int unsigned FE_AUTO_CTS = 7;
  localparam int unsigned FE_AUTO_RTS = 6;
  localparam int unsigned FE_SPECIAL  = 5;
  localparam int unsigned FE_GATE     = 4;
  localparam int unsigned MS_D_CTS    = 0;
  localparam int unsigned MS_D_DSR    = 1;
  localparam int unsigned MC_RTS      = 1;
  localparam int unsigned MC_GATED    = 6;
  localparam int unsigned IS_SPECIAL  = 4;

  localparam logic [7:0] FEATURE_RST = 8'h00;
  localparam logic [7:0] IEN_RST     = 8'h00;
  localparam logic [7:0] MCTRL_RST   = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] GATED_IEN   = 8'hF0;
  localparam logic [7:0] GATED_IST   = 8'h30;
  localparam logic [7:0] GATED_MCR   = 8'h40;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] pause2;
    logic [7:0] pause1;
    logic [7:0] resume2;
    logic [7:0] resume1;
  } umsf_chars_s;

  typedef struct packed {
    logic       en;
    logic [1:0] idx;
    logic [7:0] data;
  } umsf_char_wr_s;

  typedef enum logic [1:0] {SEND_IDLE, SEND_FIRST, SEND_SECOND} umsf_send_e;

endpackage : umsf_pkg

// ==== verilog/umsf_char_store.sv ====
// Storage for the four flow-control characters with registered outputs.
module umsf_char_store (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire umsf_pkg::umsf_char_wr_s wr,
  output umsf_pkg::umsf_chars_s       chars
);
  logic [31:0] word_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      word_reg <= 32'h0000_0000;
    end else if (wr.en) begin
      word_reg[{wr.idx, 3'h0} +: 8] <= wr.data;
    end
  end

  assign chars = umsf_pkg::umsf_chars_s'(word_reg);
endmodule : umsf_char_store

// ==== verilog/umsf_top.sv ====
// Modem status change detection, scratch storage and enhanced flow control behind AXI4-Lite.
//
// How it works
// - Change flags for DSR and CTS set when the input toggles since last read.
// - Modem interrupt raised while any of status bits 0 to 3 is set.
// - Eight-bit scratch register stores and returns software data, nothing else.
// - Auto CTS: pin high stops transmission, pin low resumes it.
// - Auto RTS: interrupt at trigger level, RTS driven high at next level.
// - Auto RTS: RTS returns low once FIFO drains below lower level.
// - Without auto RTS, RTS follows the modem control programming.
// - Readable auto RTS bit tracks the hardware flow control status.
// - Special detect: match against second pause char sets status bit 4.
// - Character bit 0 compares with received character least significant bit.
// - Gate bit set allows writes to gated enable, status, control bits.
// - Clearing the gate bit latches enhanced bits against later writes.
// - Feature bits 3:0 select software flow control, reset to zero.
// - Dual selection treats character pairs as one two-character sequence.
// - All enhanced feature control bits reset to zero.
// - Reading the modem status register clears its change bits.
// - Auto CTS halts only after the current character finishes.
// - Bits 3:2 pick transmit pairs, bits 1:0 pick receive comparison pairs.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
module umsf_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ctsPin,
  input  wire logic        dsrPin,
  input  wire logic        txBusy,
  input  wire logic        rxCharValid,
  input  wire logic [7:0]  rxChar,
  input  wire logic [4:0]  rxFillLevel,
  input  wire logic [4:0]  rxTrigLevel,
  input  wire logic [4:0]  rxNextTrigLevel,
  input  wire logic [4:0]  rxLowerTrigLevel,
  input  wire logic        flowCharReady,
  output logic             rtsPin,
  output logic             txEnable,
  output logic             modemIrq,
  output logic             rxTrigIrq,
  output logic             flowCharValid,
  output logic [7:0]       flowChar
);
  import umsf_pkg::*;

  function automatic logic isMapped(input logic [5:0] a);
    isMapped = (a <= umsf_pkg::OFF_FLOW) || (a >= umsf_pkg::OFF_CHAR0 && a <= umsf_pkg::OFF_CHAR3);
  endfunction : isMapped

  // Matches a single character or the second half of a two-character sequence.
  function automatic logic seqMatch(input logic [1:0] sel, input logic [7:0] c,
                                    input logic [7:0] a, input logic [7:0] b,
                                    input logic firstSeen);
    seqMatch = (sel == 2'h2 && c == a) || (sel == 2'h1 && c == b) ||
               (sel == 2'h3 && firstSeen && c == b);
  endfunction : seqMatch

  //////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic        awHeld_reg, wHeld_reg, bValid_reg, arReady_reg, rValid_reg, awReady_reg, wReady_reg;
  logic [5:0]  wAddr_reg;
  logic [7:0]  wData_reg;
  logic        wStrb_reg;
  logic [1:0]  bResp_reg, rResp_reg;
  logic [31:0] rData_reg;
  logic        doWrite, awTake, wTake, arTake, awHeldNext, wHeldNext, bValidNext;
  logic [31:0] rdMux;

  assign awTake     = s_axi_awvalid && awReady_reg;
  assign wTake      = s_axi_wvalid && wReady_reg;
  assign doWrite    = awHeld_reg && wHeld_reg && !bValid_reg;
  assign arTake     = s_axi_arvalid && arReady_reg;
  assign awHeldNext = (awHeld_reg || awTake) && !doWrite;
  assign wHeldNext  = (wHeld_reg || wTake) && !doWrite;
  assign bValidNext = doWrite || (bValid_reg && !s_axi_bready);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      bValid_reg  <= 1'b0;
      awReady_reg <= 1'b1;
      wReady_reg  <= 1'b1;
      bResp_reg   <= RESP_OKAY;
      wAddr_reg   <= 6'h00;
      wData_reg   <= 8'h00;
      wStrb_reg   <= 1'b0;
    end else begin
      awHeld_reg  <= awHeldNext;
      wHeld_reg   <= wHeldNext;
      bValid_reg  <= bValidNext;
      awReady_reg <= !awHeldNext && !bValidNext;
      wReady_reg  <= !wHeldNext && !bValidNext;
      if (awTake) begin
        wAddr_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_reg <= s_axi_wdata[7:0];
        wStrb_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        bResp_reg <= isMapped(wAddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
      rData_reg   <= 32'h0000_0000;
      rResp_reg   <= RESP_OKAY;
    end else if (arTake) begin
      arReady_reg <= 1'b0;
      rValid_reg  <= 1'b1;
      rData_reg   <= isMapped(s_axi_araddr) ? rdMux : 32'h0000_0000;
      rResp_reg   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_reg && s_axi_rready) begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready  = wReady_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  logic wrScratch, wrFeature, wrIen, wrIstat, wrMctrl, statusRead;
  assign wrScratch  = doWrite && wStrb_reg && wAddr_reg == OFF_SCRATCH;
  assign wrFeature  = doWrite && wStrb_reg && wAddr_reg == OFF_FEATURE;
  assign wrIen      = doWrite && wStrb_reg && wAddr_reg == OFF_IEN;
  assign wrIstat    = doWrite && wStrb_reg && wAddr_reg == OFF_ISTAT;
  assign wrMctrl    = doWrite && wStrb_reg && wAddr_reg == OFF_MCTRL;
  assign statusRead = arTake && s_axi_araddr == OFF_STATUS;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0]    scratch_reg, feature_reg, ien_reg, istat_reg, mctrl_reg;
  umsf_chars_s   chars;
  umsf_char_wr_s charWr;
  logic          gateOpen;

  assign gateOpen = feature_reg[FE_GATE];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scratch_reg <= SCRATCH_RST;
    end else if (wrScratch) begin
      scratch_reg <= wData_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      feature_reg <= FEATURE_RST;
    end else if (wrFeature) begin
      feature_reg <= wData_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ien_reg   <= IEN_RST;
      mctrl_reg <= MCTRL_RST;
    end else begin
      if (wrIen) begin
        ien_reg <= gateOpen ? wData_reg : (ien_reg & GATED_IEN) | (wData_reg & ~GATED_IEN);
      end
      if (wrMctrl) begin
        mctrl_reg <= gateOpen ? wData_reg : (mctrl_reg & GATED_MCR) | (wData_reg & ~GATED_MCR);
      end
    end
  end

  logic specialHit;
  assign specialHit = feature_reg[FE_SPECIAL] && rxCharValid && rxChar == chars.pause2;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      istat_reg <= 8'h00;
    end else begin
      if (wrIstat && gateOpen) begin
        istat_reg <= wData_reg & GATED_IST;
      end
      if (specialHit) begin
        istat_reg[IS_SPECIAL] <= 1'b1;
      end
    end
  end

  assign charWr = '{en: doWrite && wStrb_reg && wAddr_reg >= OFF_CHAR0 && wAddr_reg <= OFF_CHAR3,
                    idx: wAddr_reg[3:2], data: wData_reg};

  umsf_char_store u_store (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr      (charWr),
    .chars   (chars)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Modem status change detection.

  logic ctsPrev_reg, dsrPrev_reg, primed_reg, dCts_reg, dDsr_reg, ctsChg, dsrChg;
  assign ctsChg = primed_reg && ctsPin != ctsPrev_reg;
  assign dsrChg = primed_reg && dsrPin != dsrPrev_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      primed_reg  <= 1'b0;
      ctsPrev_reg <= 1'b0;
      dsrPrev_reg <= 1'b0;
      dCts_reg    <= 1'b0;
      dDsr_reg    <= 1'b0;
    end else begin
      primed_reg  <= 1'b1;
      ctsPrev_reg <= ctsPin;
      dsrPrev_reg <= dsrPin;
      dCts_reg    <= ctsChg || (dCts_reg && !statusRead);
      dDsr_reg    <= dsrChg || (dDsr_reg && !statusRead);
    end
  end

  logic [7:0] statusVal;
  assign statusVal = {2'h0, ~dsrPin, ~ctsPin, 2'h0, dDsr_reg, dCts_reg};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      modemIrq <= 1'b0;
    end else begin
      modemIrq <= |statusVal[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Hardware flow control.

  logic autoRts, rtsStop_reg;
  assign autoRts = feature_reg[FE_AUTO_RTS];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rtsStop_reg <= 1'b0;
      rxTrigIrq   <= 1'b0;
    end else begin
      rxTrigIrq <= autoRts && rxFillLevel >= rxTrigLevel;
      if (rxFillLevel >= rxNextTrigLevel) begin
        rtsStop_reg <= 1'b1;
      end else if (rxFillLevel < rxLowerTrigLevel) begin
        rtsStop_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rtsPin <= 1'b1;
    end else if (autoRts) begin
      rtsPin <= rxFillLevel >= rxNextTrigLevel ||
                (rtsStop_reg && rxFillLevel >= rxLowerTrigLevel);
    end else begin
      rtsPin <= !mctrl_reg[MC_RTS];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Software flow control: receive comparison and pause state.

  logic pause1Seen_reg, resume1Seen_reg, remotePause_reg, pauseHit, resumeHit;
  logic [1:0] rxSel, txSel;
  assign rxSel = feature_reg[1:0];
  assign txSel = feature_reg[3:2];

  assign pauseHit  = rxCharValid && seqMatch(rxSel, rxChar, chars.pause1, chars.pause2,
                                             pause1Seen_reg);
  assign resumeHit = rxCharValid && seqMatch(rxSel, rxChar, chars.resume1, chars.resume2,
                                             resume1Seen_reg);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pause1Seen_reg  <= 1'b0;
      resume1Seen_reg <= 1'b0;
      remotePause_reg <= 1'b0;
    end else begin
      if (rxCharValid) begin
        pause1Seen_reg  <= rxChar == chars.pause1;
        resume1Seen_reg <= rxChar == chars.resume1;
      end
      if (rxSel == 2'h0) begin
        remotePause_reg <= 1'b0;
      end else if (pauseHit) begin
        remotePause_reg <= 1'b1;
      end else if (resumeHit) begin
        remotePause_reg <= 1'b0;
      end
    end
  end

  logic haltWanted;
  assign haltWanted = (feature_reg[FE_AUTO_CTS] && ctsPin) || remotePause_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txEnable <= 1'b1;
    end else if (!haltWanted) begin
      txEnable <= 1'b1;
    end else if (!txBusy) begin
      txEnable <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Software flow control: sending pause and resume characters.

  umsf_send_e sendState_reg;
  logic       sendPause_reg, pauseSent_reg;
  logic       needPause, needResume;
  assign needPause  = txSel != 2'h0 && !pauseSent_reg && rxFillLevel >= rxNextTrigLevel;
  assign needResume = pauseSent_reg && rxFillLevel < rxLowerTrigLevel;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sendState_reg <= SEND_IDLE;
      sendPause_reg <= 1'b0;
      pauseSent_reg <= 1'b0;
      flowCharValid <= 1'b0;
      flowChar      <= 8'h00;
    end else begin
      unique case (sendState_reg)
        SEND_IDLE: begin
          if (needPause || needResume) begin
            sendPause_reg <= needPause;
            pauseSent_reg <= needPause;
            flowCharValid <= 1'b1;
            if (txSel == 2'h1) begin
              flowChar      <= needPause ? chars.pause2 : chars.resume2;
              sendState_reg <= SEND_SECOND;
            end else begin
              flowChar      <= needPause ? chars.pause1 : chars.resume1;
              sendState_reg <= SEND_FIRST;
            end
          end
        end
        SEND_FIRST: begin
          if (flowCharReady) begin
            if (txSel == 2'h3) begin
              flowChar      <= sendPause_reg ? chars.pause2 : chars.resume2;
              sendState_reg <= SEND_SECOND;
            end else begin
              flowCharValid <= 1'b0;
              sendState_reg <= SEND_IDLE;
            end
          end
        end
        SEND_SECOND: begin
          if (flowCharReady) begin
            flowCharValid <= 1'b0;
            sendState_reg <= SEND_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFF_STATUS:  rdMux[7:0] = statusVal;
      OFF_SCRATCH: rdMux[7:0] = scratch_reg;
      OFF_FEATURE: rdMux[7:0] = feature_reg;
      OFF_IEN:     rdMux[7:0] = ien_reg;
      OFF_ISTAT:   rdMux[7:0] = istat_reg;
      OFF_MCTRL:   rdMux[7:0] = mctrl_reg;
      OFF_FLOW:    rdMux[3:0] = {remotePause_reg, rtsStop_reg && autoRts, rtsPin, txEnable};
      6'h20:       rdMux[7:0] = chars.resume1;
      6'h24:       rdMux[7:0] = chars.resume2;
      6'h28:       rdMux[7:0] = chars.pause1;
      OFF_CHAR3:   rdMux[7:0] = chars.pause2;
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_cts_change_flag: assert property (ctsChg |=> dCts_reg)
    else $error("CTS change not flagged");
  a_dsr_change_flag: assert property (dsrChg |=> dDsr_reg)
    else $error("DSR change not flagged");
  a_status_read_clr: assert property (statusRead && !ctsChg && !dsrChg |=> !dCts_reg && !dDsr_reg)
    else $error("Status read did not clear change flags");
  a_modem_irq_follow: assert property (dCts_reg || dDsr_reg |=> modemIrq)
    else $error("Modem interrupt missing");
  a_scratch_hold: assert property (!wrScratch |=> $stable(scratch_reg))
    else $error("Scratch changed without write");
  a_cts_halt: assert property (feature_reg[FE_AUTO_CTS] && ctsPin && !txBusy |=> !txEnable)
    else $error("Auto CTS did not halt");
  a_char_finish: assert property (txEnable && txBusy |=> txEnable)
    else $error("Halted during a character");
  a_rts_raise: assert property (autoRts && rxFillLevel >= rxNextTrigLevel |=> rtsPin)
    else $error("Auto RTS not raised");
  a_rts_drop: assert property (autoRts && rxFillLevel < rxLowerTrigLevel |=> !rtsPin)
    else $error("Auto RTS not dropped");
  a_rts_manual: assert property (!autoRts |=> rtsPin == !$past(mctrl_reg[MC_RTS]))
    else $error("Manual RTS mismatch");
  a_special_set: assert property (specialHit |=> istat_reg[IS_SPECIAL])
    else $error("Special character not flagged");
  a_gate_protect: assert property (wrIen && !gateOpen |=> ien_reg[7:4] == $past(ien_reg[7:4]))
    else $error("Gated enable bits changed");

  c_status_read: cover property (dCts_reg ##1 statusRead);
  c_cts_halt: cover property (txEnable ##1 !txEnable);
  c_dual_send: cover property (sendState_reg == SEND_FIRST ##1 sendState_reg == SEND_SECOND);
  c_special: cover property (specialHit);
endmodule : umsf_top

// ==== sim/umsf_peer_model.sv ====
// Behavioural modem peer: handshake pins, received characters and a flow character sink.
module umsf_peer_model (
  input  wire logic       clk_sys,
  input  wire logic       flowCharValid,
  input  wire logic [7:0] flowChar,
  output logic            flowCharReady,
  output logic            ctsPin,
  output logic            dsrPin,
  output logic            txBusy,
  output logic            rxCharValid,
  output logic [7:0]      rxChar
);
  timeunit 1ns;
  timeprecision 1ns;
  int         stall   = 0;
  int         waitCnt = 0;
  logic [7:0] sent[$];

  initial begin
    flowCharReady = 1'b0;
    ctsPin        = 1'b0;
    dsrPin        = 1'b0;
    txBusy        = 1'b0;
    rxCharValid   = 1'b0;
    rxChar        = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Accepts flow characters after a programmable stall, recording each one taken.
  always @(posedge clk_sys) begin
    if (flowCharValid && flowCharReady) sent.push_back(flowChar);
    flowCharReady <= flowCharValid && !flowCharReady && (waitCnt >= stall);
    waitCnt       <= (flowCharValid && !flowCharReady) ? waitCnt + 1 : 0;
  end

  task automatic set_pins(input logic cts, input logic dsr, input logic busy);
    @(posedge clk_sys);
    ctsPin <= cts;
    dsrPin <= dsr;
    txBusy <= busy;
  endtask : set_pins

  task automatic send_char(input logic [7:0] c);
    @(posedge clk_sys);
    rxCharValid <= 1'b1;
    rxChar      <= c;
    @(posedge clk_sys);
    rxCharValid <= 1'b0;
    rxChar      <= ~c;
  endtask : send_char
endmodule : umsf_peer_model

// ==== sim/umsf_top_test.sv ====
// Self-checking bench for the modem status and flow control block.
module umsf_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ctsPin, dsrPin, txBusy, rxCharValid, flowCharReady, rtsPin;
  logic        txEnable, modemIrq, rxTrigIrq, flowCharValid;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  rxChar, flowChar;
  logic [4:0]  rxFillLevel, rxTrigLevel, rxNextTrigLevel, rxLowerTrigLevel;
  logic [7:0]  expq[$];
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycleCount = 0;

  umsf_top u_dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ctsPin(ctsPin), .dsrPin(dsrPin), .txBusy(txBusy),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxFillLevel(rxFillLevel),
    .rxTrigLevel(rxTrigLevel), .rxNextTrigLevel(rxNextTrigLevel),
    .rxLowerTrigLevel(rxLowerTrigLevel), .flowCharReady(flowCharReady), .rtsPin(rtsPin),
    .txEnable(txEnable), .modemIrq(modemIrq), .rxTrigIrq(rxTrigIrq),
    .flowCharValid(flowCharValid), .flowChar(flowChar));

  umsf_peer_model u_peer (.clk_sys(clk_sys), .flowCharValid(flowCharValid),
    .flowChar(flowChar), .flowCharReady(flowCharReady), .ctsPin(ctsPin), .dsrPin(dsrPin),
    .txBusy(txBusy), .rxCharValid(rxCharValid), .rxChar(rxChar));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Readies are sampled mid-cycle so each channel is released right after its own handshake.
  task automatic xfer(input logic we, input logic [5:0] a, input logic [7:0] d);
    logic aw, w, ar, done;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= we;
    s_axi_wvalid  <= we;
    s_axi_bready  <= we;
    s_axi_arvalid <= !we;
    s_axi_rready  <= !we;
    done = 1'b0;
    while (!done) begin
      @(negedge clk_sys);
      done = we ? s_axi_bvalid : s_axi_rvalid;
      resp = we ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      aw   = s_axi_awready;
      w    = s_axi_wready;
      ar   = s_axi_arready;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rm(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rdat & mask, exp);
  endtask : rm

  task automatic rg(input logic [5:0] a, input logic [31:0] exp);
    rm(a, 32'hFFFFFFFF, exp);
  endtask : rg

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'h1;
    rxFillLevel = 5'h00;
    rxTrigLevel = 5'h08;
    rxNextTrigLevel = 5'h0C;
    rxLowerTrigLevel = 5'h04;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rg(umsf_pkg::OFF_FEATURE, 32'h00000000);
    rg(umsf_pkg::OFF_STATUS, 32'h00000030);
    wr(umsf_pkg::OFF_SCRATCH, 8'hA5);
    s_axi_wstrb <= 4'h0;
    wr(umsf_pkg::OFF_SCRATCH, 8'h00);
    s_axi_wstrb <= 4'h1;
    rg(umsf_pkg::OFF_SCRATCH, 32'h000000A5);
    rg(6'h1C, 32'h00000000);
    chk({30'h0, resp}, {30'h0, umsf_pkg::RESP_SLVERR});
    wr(6'h1C, 8'h3C);
    chk({30'h0, resp}, {30'h0, umsf_pkg::RESP_SLVERR});
    u_peer.set_pins(1'b1, 1'b0, 1'b0);
    settle();
    chk({31'h0, modemIrq}, 32'h00000001);
    rg(umsf_pkg::OFF_STATUS, 32'h00000021);
    rg(umsf_pkg::OFF_STATUS, 32'h00000020);
    chk({31'h0, modemIrq}, 32'h00000000);
    u_peer.set_pins(1'b1, 1'b1, 1'b0);
    settle();
    rg(umsf_pkg::OFF_STATUS, 32'h00000002);
    u_peer.set_pins(1'b0, 1'b0, 1'b1);
    settle();
    rg(umsf_pkg::OFF_STATUS, 32'h00000033);
    wr(umsf_pkg::OFF_FEATURE, 8'h80);
    u_peer.set_pins(1'b1, 1'b0, 1'b1);
    settle();
    chk({31'h0, txEnable}, 32'h00000001);
    u_peer.set_pins(1'b1, 1'b0, 1'b0);
    settle();
    chk({31'h0, txEnable}, 32'h00000000);
    u_peer.set_pins(1'b0, 1'b0, 1'b0);
    settle();
    chk({31'h0, txEnable}, 32'h00000001);
    wr(umsf_pkg::OFF_FEATURE, 8'h40);
    rg(umsf_pkg::OFF_FEATURE, 32'h00000040);
    chk({31'h0, rtsPin}, 32'h00000000);
    rxFillLevel <= 5'h0C;
    settle();
    chk({30'h0, rtsPin, rxTrigIrq}, 32'h00000003);
    rm(umsf_pkg::OFF_FLOW, 32'h00000004, 32'h00000004);
    rxFillLevel <= 5'h06;
    settle();
    chk({31'h0, rtsPin}, 32'h00000001);
    rxFillLevel <= 5'h03;
    settle();
    chk({31'h0, rtsPin}, 32'h00000000);
    wr(umsf_pkg::OFF_FEATURE, 8'h00);
    wr(umsf_pkg::OFF_MCTRL, 8'h02);
    settle();
    chk({31'h0, rtsPin}, 32'h00000000);
    wr(umsf_pkg::OFF_MCTRL, 8'h00);
    settle();
    chk({31'h0, rtsPin}, 32'h00000001);
    wr(umsf_pkg::OFF_IEN, 8'hFF);
    rg(umsf_pkg::OFF_IEN, 32'h0000000F);
    wr(umsf_pkg::OFF_FEATURE, 8'h10);
    wr(umsf_pkg::OFF_IEN, 8'hFF);
    rg(umsf_pkg::OFF_IEN, 32'h000000FF);
    wr(umsf_pkg::OFF_MCTRL, 8'h40);
    rg(umsf_pkg::OFF_MCTRL, 32'h00000040);
    wr(umsf_pkg::OFF_FEATURE, 8'h00);
    wr(umsf_pkg::OFF_IEN, 8'h00);
    rg(umsf_pkg::OFF_IEN, 32'h000000F0);
    wr(umsf_pkg::OFF_MCTRL, 8'h00);
    rg(umsf_pkg::OFF_MCTRL, 32'h00000040);
    wr(umsf_pkg::OFF_CHAR3, 8'h5A);
    wr(umsf_pkg::OFF_FEATURE, 8'h20);
    u_peer.send_char(8'h5B);
    settle();
    rm(umsf_pkg::OFF_ISTAT, 32'h00000010, 32'h00000000);
    u_peer.send_char(8'h5A);
    settle();
    rm(umsf_pkg::OFF_ISTAT, 32'h00000010, 32'h00000010);
    for (int i = 0; i < 4; i++) wr(umsf_pkg::OFF_CHAR0 + 6'(4 * i), 8'h11 + 8'(i));
    // Each transmit selection is run with a slower sink than the last.
    for (int s = 1; s < 4; s++) begin
      wr(umsf_pkg::OFF_FEATURE, 8'(s << 2));
      u_peer.stall = s - 1;
      u_peer.sent.delete();
      expq.delete();
      rxFillLevel <= 5'h0C;
      repeat (40) @(posedge clk_sys);
      rxFillLevel <= 5'h00;
      repeat (40) @(posedge clk_sys);
      if (s[1]) expq.push_back(8'h13);
      if (s[0]) expq.push_back(8'h14);
      if (s[1]) expq.push_back(8'h11);
      if (s[0]) expq.push_back(8'h12);
      chk(32'(u_peer.sent.size()), 32'(expq.size()));
      foreach (expq[i]) chk({24'h0, u_peer.sent[i]}, {24'h0, expq[i]});
    end
    wr(umsf_pkg::OFF_FEATURE, 8'h02);
    u_peer.send_char(8'h13);
    settle();
    chk({31'h0, txEnable}, 32'h0);
    u_peer.send_char(8'h11);
    settle();
    chk({31'h0, txEnable}, 32'h1);
    complete_run();
  end
endmodule : umsf_top_test
